// >>> radio_link_pkg.sv
/*
 * Shared constants for the host serial link of the packet radio module.
 * Assumes a single 40 MHz clock on both ends of the link.
 */
package radio_link_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int BAUD = 19_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD;
    localparam int CHAR_BITS = 10;
    localparam int GAP_CHARS = 2;
    localparam int GAP_CYCLES = GAP_CHARS * CHAR_BITS * BIT_CYCLES;
    localparam int BUF_DEPTH = 180;
    localparam int FULL_MARGIN = 2;
    localparam int RF_BYTE_US = 800;
    localparam int RF_OVERHEAD_US = 13_200;
    localparam int RF_HALF_CYCLES = RF_BYTE_US * (CLK_HZ / 1_000_000) / 16;
    localparam int PACKET_WAIT_CYCLES = (RF_OVERHEAD_US + BUF_DEPTH * RF_BYTE_US) * (CLK_HZ / 1_000_000);
    localparam logic LINE_IDLE = 1'b1;
endpackage

// >>> radio_host_if.sv
/*
 * Serial data and handshake lines between host and radio module.
 * Assumes both ends share the clock of the surrounding system.
 */
`timescale 1ns/1ps
interface radio_host_if;
    logic host_char_in;
    logic received_char_out;
    logic not_ready_flow_out;
    logic host_ready_n;

    modport device (
        input host_char_in,
        input host_ready_n,
        output received_char_out,
        output not_ready_flow_out
    );

    modport host (
        output host_char_in,
        output host_ready_n,
        input received_char_out,
        input not_ready_flow_out
    );
endinterface

// >>> radio_device_end.sv
/*
 * Radio module end: host character receiver, shared packet buffer,
 * Manchester radio transmitter and receiver, and host character streamer.
 * Assumes the radio pins and host lines are synchronous to clk_i.
 */
`timescale 1ns/1ps
module radio_device_end #(
    parameter int BIT_CYCLES = radio_link_pkg::BIT_CYCLES,
    parameter int GAP_CYCLES = radio_link_pkg::GAP_CYCLES,
    parameter int RF_HALF_CYCLES = radio_link_pkg::RF_HALF_CYCLES,
    parameter int DEPTH = radio_link_pkg::BUF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    radio_host_if.device host_if,
    input wire logic radio_rx_i,
    output logic radio_tx_o,
    output logic radio_tx_en_o,
    output logic radio_rx_en_o,
    output logic frame_error_o
);
    import radio_link_pkg::*;

    typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} urx_t;
    typedef enum logic [1:0] {M_LOAD, M_SEND, M_RECV, M_STREAM} mode_t;

    urx_t urx_state;
    logic [31:0] urx_cnt;
    logic [2:0] urx_bit;
    logic [7:0] urx_sh;
    logic urx_strobe;

    mode_t mode;
    logic [7:0] buf_mem [DEPTH];
    logic [7:0] count;
    logic [31:0] gap_cnt;
    logic rf_prev;

    logic [31:0] tx_cnt;
    logic tx_half;
    logic tx_start;
    logic [2:0] tx_bit;
    logic [7:0] tx_idx;
    logic [7:0] tx_sh;
    logic [7:0] tx_sum;
    logic tx_cur;

    logic [31:0] rf_cnt;
    logic rf_phase;
    logic rf_h0;
    logic rf_first;
    logic [2:0] rf_bit;
    logic [7:0] rf_sh;
    logic [7:0] rf_idx;
    logic [7:0] rf_len;
    logic [7:0] rf_sum;
    logic [7:0] rf_byte;

    logic st_active;
    logic [3:0] st_bit;
    logic [31:0] st_cnt;
    logic [9:0] st_sh;
    logic [7:0] st_idx;

    assign rf_byte = {rf_h0, rf_sh[7:1]};
    assign tx_cur = tx_start ? 1'b1 : tx_sh[0];

    ////////////////////////////////////////////////////////////////////////
    // host character receiver
    always_ff @(posedge clk_i) begin
        urx_strobe <= 1'b0;
        if (rst_i) begin
            urx_state <= U_IDLE;
            urx_cnt <= '0;
            urx_bit <= '0;
            urx_sh <= '0;
        end else begin
            unique case (urx_state)
                U_IDLE: if (!host_if.host_char_in) begin
                    urx_state <= U_START;
                    urx_cnt <= 32'(BIT_CYCLES / 2);
                end
                U_START: if (urx_cnt == 0) begin
                    urx_cnt <= 32'(BIT_CYCLES - 1);
                    urx_bit <= '0;
                    urx_state <= host_if.host_char_in ? U_IDLE : U_DATA;
                end else begin
                    urx_cnt <= urx_cnt - 32'd1;
                end
                U_DATA: if (urx_cnt == 0) begin
                    urx_cnt <= 32'(BIT_CYCLES - 1);
                    urx_sh <= {host_if.host_char_in, urx_sh[7:1]};
                    urx_bit <= urx_bit + 3'd1;
                    if (urx_bit == 3'd7) begin
                        urx_state <= U_STOP;
                    end
                end else begin
                    urx_cnt <= urx_cnt - 32'd1;
                end
                U_STOP: if (urx_cnt == 0) begin
                    urx_state <= U_IDLE;
                    urx_strobe <= host_if.host_char_in;
                end else begin
                    urx_cnt <= urx_cnt - 32'd1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // end-of-data gap timer
    always_ff @(posedge clk_i) begin
        if (rst_i || mode != M_LOAD || urx_state != U_IDLE || urx_strobe) begin
            gap_cnt <= '0;
        end else if (count != 0 && gap_cnt < 32'(GAP_CYCLES)) begin
            gap_cnt <= gap_cnt + 32'd1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rf_prev <= 1'b0;
        end else begin
            rf_prev <= radio_rx_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer, mode and the three engines that share it
    always_ff @(posedge clk_i) begin
        frame_error_o <= 1'b0;
        if (rst_i) begin
            mode <= M_LOAD;
            count <= '0;
            {tx_cnt, tx_half, tx_start, tx_bit, tx_idx, tx_sh, tx_sum} <= '0;
            {rf_cnt, rf_phase, rf_h0, rf_first, rf_bit, rf_sh, rf_idx, rf_len, rf_sum} <= '0;
            {st_active, st_bit, st_cnt, st_sh, st_idx} <= '0;
        end else begin
            unique case (mode)
                M_LOAD: begin
                    if (urx_strobe && count < 8'(DEPTH)) begin
                        buf_mem[count] <= urx_sh;
                        count <= count + 8'd1;
                    end
                    if (count == 8'(DEPTH) || gap_cnt == 32'(GAP_CYCLES)) begin
                        mode <= M_SEND;
                        tx_start <= 1'b1;
                        tx_half <= 1'b0;
                        tx_bit <= '0;
                        tx_idx <= '0;
                        tx_sh <= count;
                        tx_sum <= count;
                        tx_cnt <= 32'(RF_HALF_CYCLES - 1);
                    end else if (count == 0 && urx_state == U_IDLE && radio_rx_i && !rf_prev) begin
                        mode <= M_RECV;
                        rf_cnt <= 32'(RF_HALF_CYCLES / 2);
                        rf_phase <= 1'b0;
                        rf_first <= 1'b1;
                        rf_bit <= '0;
                        rf_idx <= '0;
                    end
                end
                M_SEND: if (tx_cnt != 0) begin
                    tx_cnt <= tx_cnt - 32'd1;
                end else begin
                    tx_cnt <= 32'(RF_HALF_CYCLES - 1);
                    tx_half <= !tx_half;
                    if (tx_half) begin
                        if (tx_start) begin
                            tx_start <= 1'b0;
                        end else if (tx_bit != 3'd7) begin
                            tx_bit <= tx_bit + 3'd1;
                            tx_sh <= {1'b0, tx_sh[7:1]};
                        end else begin
                            tx_bit <= '0;
                            tx_idx <= tx_idx + 8'd1;
                            if (tx_idx == count + 8'd1) begin
                                mode <= M_LOAD;
                                count <= '0;
                            end else if (tx_idx < count) begin
                                tx_sh <= buf_mem[tx_idx];
                                tx_sum <= tx_sum + buf_mem[tx_idx];
                            end else begin
                                tx_sh <= tx_sum;
                            end
                        end
                    end
                end
                M_RECV: if (rf_cnt != 0) begin
                    rf_cnt <= rf_cnt - 32'd1;
                end else begin
                    rf_cnt <= 32'(RF_HALF_CYCLES - 1);
                    rf_phase <= !rf_phase;
                    if (!rf_phase) begin
                        rf_h0 <= radio_rx_i;
                    end else if (rf_h0 == radio_rx_i) begin
                        mode <= M_LOAD;
                        frame_error_o <= 1'b1;
                    end else if (rf_first) begin
                        rf_first <= 1'b0;
                    end else begin
                        rf_sh <= rf_byte;
                        rf_bit <= rf_bit + 3'd1;
                        if (rf_bit == 3'd7) begin
                            rf_idx <= rf_idx + 8'd1;
                            if (rf_idx == 0) begin
                                rf_len <= rf_byte;
                                rf_sum <= rf_byte;
                                if (rf_byte == 0 || rf_byte > 8'(DEPTH)) begin
                                    mode <= M_LOAD;
                                    frame_error_o <= 1'b1;
                                end
                            end else if (rf_idx <= rf_len) begin
                                buf_mem[rf_idx - 8'd1] <= rf_byte;
                                rf_sum <= rf_sum + rf_byte;
                            end else if (rf_byte == rf_sum) begin
                                mode <= M_STREAM;
                                count <= rf_len;
                                st_idx <= '0;
                                st_active <= 1'b0;
                            end else begin
                                mode <= M_LOAD;
                                frame_error_o <= 1'b1;
                            end
                        end
                    end
                end
                M_STREAM: if (!st_active) begin
                    if (st_idx == count) begin
                        mode <= M_LOAD;
                        count <= '0;
                    end else if (!host_if.host_ready_n) begin
                        st_active <= 1'b1;
                        st_sh <= {1'b1, buf_mem[st_idx], 1'b0};
                        st_bit <= '0;
                        st_cnt <= 32'(BIT_CYCLES - 1);
                    end
                end else if (st_cnt != 0) begin
                    st_cnt <= st_cnt - 32'd1;
                end else begin
                    st_cnt <= 32'(BIT_CYCLES - 1);
                    st_sh <= {1'b1, st_sh[9:1]};
                    st_bit <= st_bit + 4'd1;
                    if (st_bit == 4'd9) begin
                        st_active <= 1'b0;
                        st_idx <= st_idx + 8'd1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            radio_tx_o <= 1'b0;
            radio_tx_en_o <= 1'b0;
            radio_rx_en_o <= 1'b0;
            host_if.received_char_out <= LINE_IDLE;
            host_if.not_ready_flow_out <= 1'b1;
        end else begin
            radio_tx_en_o <= (mode == M_SEND);
            radio_rx_en_o <= (mode != M_SEND);
            radio_tx_o <= (mode == M_SEND) ? (tx_cur ^ tx_half) : 1'b0;
            host_if.received_char_out <= (mode == M_STREAM && st_active) ? st_sh[0] : LINE_IDLE;
            host_if.not_ready_flow_out <= (mode != M_LOAD) || (count >= 8'(DEPTH - FULL_MARGIN));
        end
    end
endmodule

// >>> radio_host_end.sv
/*
 * Host end: sends user bytes to the radio module as one packet of
 * back-to-back characters and delivers received characters to the user.
 * Assumes the module lines are synchronous to clk_i.
 */
`timescale 1ns/1ps
module radio_host_end #(
    parameter int BIT_CYCLES = radio_link_pkg::BIT_CYCLES,
    parameter int PACKET_WAIT_CYCLES = radio_link_pkg::PACKET_WAIT_CYCLES,
    parameter int MAX_CHARS = radio_link_pkg::BUF_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    radio_host_if.host dev_if,
    input wire logic [7:0] send_data_i,
    input wire logic send_valid_i,
    output logic send_ready_o,
    input wire logic recv_hold_i,
    output logic [7:0] recv_data_o,
    output logic recv_valid_o
);
    import radio_link_pkg::*;

    typedef enum logic [1:0] {T_IDLE, T_SEND, T_WAIT} htx_t;
    typedef enum logic [1:0] {U_IDLE, U_START, U_DATA, U_STOP} urx_t;

    htx_t tx_state;
    logic [31:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic [7:0] sent;
    logic pend;
    logic [7:0] pend_data;
    logic take;

    urx_t urx_state;
    logic [31:0] urx_cnt;
    logic [2:0] urx_bit;
    logic [7:0] urx_sh;

    assign take = send_valid_i && send_ready_o;

    ////////////////////////////////////////////////////////////////////////
    // packet sender
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_state <= T_IDLE;
            tx_cnt <= '0;
            tx_bit <= '0;
            tx_sh <= '1;
            sent <= '0;
            pend <= 1'b0;
            pend_data <= '0;
            send_ready_o <= 1'b0;
        end else begin
            unique case (tx_state)
                T_IDLE: begin
                    send_ready_o <= !dev_if.not_ready_flow_out && !take;
                    if (take) begin
                        tx_state <= T_SEND;
                        tx_sh <= {1'b1, send_data_i, 1'b0};
                        tx_bit <= '0;
                        tx_cnt <= 32'(BIT_CYCLES - 1);
                        sent <= 8'd1;
                    end
                end
                T_SEND: begin
                    if (take) begin
                        pend <= 1'b1;
                        pend_data <= send_data_i;
                    end
                    send_ready_o <= (tx_bit == 4'd9) && (tx_cnt > 32'd1) && !pend && !take
                                    && (sent < 8'(MAX_CHARS)) && !dev_if.not_ready_flow_out;
                    if (tx_cnt != 0) begin
                        tx_cnt <= tx_cnt - 32'd1;
                    end else begin
                        tx_cnt <= 32'(BIT_CYCLES - 1);
                        if (tx_bit != 4'd9) begin
                            tx_bit <= tx_bit + 4'd1;
                            tx_sh <= {1'b1, tx_sh[9:1]};
                        end else if (pend) begin
                            tx_sh <= {1'b1, pend_data, 1'b0};
                            tx_bit <= '0;
                            pend <= 1'b0;
                            sent <= sent + 8'd1;
                        end else begin
                            tx_state <= T_WAIT;
                            tx_cnt <= 32'(PACKET_WAIT_CYCLES - 1);
                        end
                    end
                end
                T_WAIT: begin
                    send_ready_o <= 1'b0;
                    if (tx_cnt != 0) begin
                        tx_cnt <= tx_cnt - 32'd1;
                    end else begin
                        tx_state <= T_IDLE;
                    end
                end
                default: tx_state <= T_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dev_if.host_char_in <= LINE_IDLE;
            dev_if.host_ready_n <= 1'b1;
        end else begin
            dev_if.host_char_in <= (tx_state == T_SEND) ? tx_sh[0] : LINE_IDLE;
            dev_if.host_ready_n <= recv_hold_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // character receiver, always listening
    always_ff @(posedge clk_i) begin
        recv_valid_o <= 1'b0;
        if (rst_i) begin
            urx_state <= U_IDLE;
            urx_cnt <= '0;
            urx_bit <= '0;
            urx_sh <= '0;
            recv_data_o <= '0;
        end else begin
            unique case (urx_state)
                U_IDLE: if (!dev_if.received_char_out) begin
                    urx_state <= U_START;
                    urx_cnt <= 32'(BIT_CYCLES / 2);
                end
                U_START: if (urx_cnt == 0) begin
                    urx_cnt <= 32'(BIT_CYCLES - 1);
                    urx_bit <= '0;
                    urx_state <= dev_if.received_char_out ? U_IDLE : U_DATA;
                end else begin
                    urx_cnt <= urx_cnt - 32'd1;
                end
                U_DATA: if (urx_cnt == 0) begin
                    urx_cnt <= 32'(BIT_CYCLES - 1);
                    urx_sh <= {dev_if.received_char_out, urx_sh[7:1]};
                    urx_bit <= urx_bit + 3'd1;
                    if (urx_bit == 3'd7) begin
                        urx_state <= U_STOP;
                    end
                end else begin
                    urx_cnt <= urx_cnt - 32'd1;
                end
                U_STOP: if (urx_cnt == 0) begin
                    urx_state <= U_IDLE;
                    if (dev_if.received_char_out) begin
                        recv_valid_o <= 1'b1;
                        recv_data_o <= urx_sh;
                    end
                end else begin
                    urx_cnt <= urx_cnt - 32'd1;
                end
            endcase
        end
    end
endmodule

// >>> radio_host_serial_packet_buffer_chk.sv
/*
 * Checker on the host lines of the first radio module.
 * Takes the interface signals plus the shared clock and sync reset.
 */
`timescale 1ns/1ps
module radio_host_serial_packet_buffer_chk #(
    parameter int BIT_CYCLES = radio_link_pkg::BIT_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic host_char_in,
    input wire logic received_char_out,
    input wire logic not_ready_flow_out,
    input wire logic host_ready_n
);
    localparam int CHAR_CYCLES = radio_link_pkg::CHAR_BITS * BIT_CYCLES;
    // characters stored when busy must be up
    localparam int BUSY_AT = radio_link_pkg::BUF_DEPTH - radio_link_pkg::FULL_MARGIN;
    int icnt;
    int ocnt;
    int ichars;
    int idle;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    // character phase counters, 0 while the line is idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            icnt <= 0;
        end else if (icnt != 0 || !host_char_in) begin
            icnt <= (icnt == CHAR_CYCLES - 1) ? 0 : icnt + 1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ocnt <= 0;
        end else if (ocnt != 0 || !received_char_out) begin
            ocnt <= (ocnt == CHAR_CYCLES - 1) ? 0 : ocnt + 1;
        end
    end
    // characters of the current burst, cleared by an idle stretch
    always_ff @(posedge clk_i) begin
        if (rst_i || icnt != 0 || !host_char_in) begin
            idle <= 0;
        end else begin
            idle <= idle + 1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || idle > 2 * BIT_CYCLES) begin
            ichars <= 0;
        end else if (icnt == CHAR_CYCLES - 1) begin
            ichars <= ichars + 1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_busy_after_reset: assert property ($past(rst_i) && !rst_i |=> !not_ready_flow_out)
        else $error("busy still high after reset");
    a_out_start_low: assert property (ocnt > 0 && ocnt < BIT_CYCLES |-> !received_char_out)
        else $error("start bit on output not low");
    a_out_stop_high: assert property (ocnt >= 9 * BIT_CYCLES |-> received_char_out)
        else $error("stop bit on output not high");
    a_in_start_low: assert property (icnt > 0 && icnt < BIT_CYCLES |-> !host_char_in)
        else $error("start bit on input not low");
    a_in_stop_high: assert property (icnt >= 9 * BIT_CYCLES |-> host_char_in)
        else $error("stop bit on input not high");
    a_busy_while_stream: assert property (ocnt >= 2 |-> not_ready_flow_out)
        else $error("busy low while streaming to host");
    a_stream_needs_ready: assert property (ocnt == 1 |->
        !$past(host_ready_n, 2) || !$past(host_ready_n, 3) || !$past(host_ready_n, 4))
        else $error("character sent while host not ready");
    a_host_checks_busy: assert property (icnt == 1 |->
        !$past(not_ready_flow_out, 2) || !$past(not_ready_flow_out, 3) || !$past(not_ready_flow_out, 4))
        else $error("host sent while busy");
    // busy follows the stored count one cycle after the last stop bit
    a_busy_near_full: assert property (icnt == CHAR_CYCLES - 1 && ichars == BUSY_AT - 1 |=> not_ready_flow_out)
        else $error("busy not raised two before full");
    a_ready_below_full: assert property (icnt == CHAR_CYCLES - 1 && ichars == BUSY_AT - 2 |-> !not_ready_flow_out)
        else $error("busy raised too early");
    c_near_full: cover property (ichars == BUSY_AT);
    c_stream_char: cover property (ocnt == CHAR_CYCLES - 1);
    c_host_burst: cover property (icnt == 1 && ichars > 2);
endmodule

// >>> radio_host_serial_packet_buffer_bench.sv
/*
 * Bench: two host ends and two module ends, radios cross-wired.
 * Assumes shortened bit, gap, half-symbol and host wait counts.
 */
`timescale 1ns/1ps
module radio_host_serial_packet_buffer_bench;
    import radio_link_pkg::*;
    localparam int BIT = 8;
    localparam logic [7:0] CORNER [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
    logic clk_i = 0;
    logic rst_i = 1;
    logic [7:0] sd [2] = '{8'h00, 8'h00};
    logic [1:0] sv = 2'h0;
    logic [1:0] hold = 2'h0;
    logic [1:0] sr, rv, tx, txen, rxen, ferr;
    logic [7:0] rd [2];
    logic [7:0] got [2][$];
    logic [7:0] sent [$];
    logic [31:0] seed = 32'h51EC;
    bit both [2] = '{0, 0};
    bit bad [2] = '{0, 0};
    bit txq [2] = '{0, 0};
    int txc [2] = '{0, 0};
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    int base;
    radio_host_if hif [2] ();
    always #12.5 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////
    for (genvar k = 0; k < 2; k++) begin : side
        radio_host_end #(.BIT_CYCLES(BIT), .PACKET_WAIT_CYCLES(2000)) radio_host_end_inst (.clk_i(clk_i),
            .rst_i(rst_i), .dev_if(hif[k].host), .send_data_i(sd[k]), .send_valid_i(sv[k]), .send_ready_o(sr[k]),
            .recv_hold_i(hold[k]), .recv_data_o(rd[k]), .recv_valid_o(rv[k]));
        radio_device_end #(.BIT_CYCLES(BIT), .GAP_CYCLES(2 * 10 * BIT), .RF_HALF_CYCLES(8)) radio_device_end_inst (
            .clk_i(clk_i), .rst_i(rst_i), .host_if(hif[k].device), .radio_rx_i(tx[1 - k]), .radio_tx_o(tx[k]),
            .radio_tx_en_o(txen[k]), .radio_rx_en_o(rxen[k]), .frame_error_o(ferr[k]));
        always @(posedge clk_i) begin
            if (rv[k]) got[k].push_back(rd[k]);
            if (txen[k] && rxen[k]) both[k] = 1;
            if (ferr[k]) bad[k] = 1;
            if (txen[k] && !txq[k]) txc[k]++;
            txq[k] = txen[k];
        end
    end
    radio_host_serial_packet_buffer_chk #(.BIT_CYCLES(BIT)) radio_host_serial_packet_buffer_chk_inst (
        .clk_i(clk_i), .rst_i(rst_i), .host_char_in(hif[0].host_char_in),
        .received_char_out(hif[0].received_char_out), .not_ready_flow_out(hif[0].not_ready_flow_out),
        .host_ready_n(hif[0].host_ready_n));
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one burst from host k, valid held until taken
    task automatic send(input int k, input int n, input bit corner);
        logic [7:0] b;
        sent.delete();
        for (int i = 0; i < n; i++) begin
            b = corner ? CORNER[i % 4] : rnd();
            sent.push_back(b);
            @(negedge clk_i);
            sd[k] = b;
            sv[k] = 1'b1;
            // ready is settled at the falling edge before the taking edge
            while (sr[k] !== 1'b1) @(negedge clk_i);
            @(posedge clk_i);
        end
        @(negedge clk_i);
        sv[k] = 1'b0;
    endtask
    task automatic expect_rx(input int k, input string name);
        for (int c = 0; c < 40000 && got[k].size() < sent.size(); c++) @(posedge clk_i);
        check({name, " count"}, got[k].size(), sent.size());
        foreach (sent[i]) check(name, got[k][i], sent[i]);
        got[k].delete();
        repeat (20) @(posedge clk_i);
        $display("test %s done", name);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 100000) begin
            mismatches++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        send(0, 4, 1'b1);
        expect_rx(1, "corner");
        send(0, 4, 1'b1);
        expect_rx(1, "repeat");
        check("frames", txc[0], 2);
        // busy rises at 178, so the burst closes on the gap
        send(0, 179, 1'b0);
        expect_rx(1, "near_full");
        @(negedge clk_i);
        hold[1] = 1'b1;
        send(0, 3, 1'b0);
        repeat (2500) @(posedge clk_i);
        check("held", got[1].size(), 0);
        @(negedge clk_i);
        hold[1] = 1'b0;
        expect_rx(1, "released");
        base = txc[0] + txc[1];
        for (int r = 0; r < 3; r++) begin
            send(r % 2, 1 + rnd() % 10, 1'b0);
            expect_rx(1 - r % 2, "random");
        end
        check("frames", txc[0] + txc[1], base + 3);
        check("half_duplex", both[0] | both[1], 0);
        check("frame_error", bad[0] | bad[1], 0);
        end_sim();
    end
endmodule
